// ===== rtl/strap_pkg.sv
// constants for the power-on strap capture block
package strap_pkg;

	// register indices on the index/data port
	localparam logic [7:0] IDX_STRAP_LOW  = 8'h4A;
	localparam logic [7:0] IDX_STRAP_MID  = 8'h4B;
	localparam logic [7:0] IDX_STRAP_HIGH = 8'h4C;

	// register width and total number of strap pins
	localparam int unsigned REG_W      = 8;
	localparam int unsigned STRAP_PINS = 18;

	// field positions inside strap_capture_low
	localparam int unsigned LOW_ETH_TXD_LSB  = 0;
	localparam int unsigned LOW_ETH_TXEN_BIT = 4;
	localparam int unsigned LOW_GIO_WR_BIT   = 5;
	localparam int unsigned LOW_GIO_RD_BIT   = 6;
	localparam int unsigned LOW_DACK1_BIT    = 7;

	// field positions inside strap_capture_mid
	localparam int unsigned MID_LBA22_BIT  = 0;
	localparam int unsigned MID_LBA23_BIT  = 1;
	localparam int unsigned MID_LBA24_BIT  = 2;
	localparam int unsigned MID_MDC_BIT    = 3;
	localparam int unsigned MID_UART_BIT   = 4;
	localparam int unsigned MID_DMATC_BIT  = 5;
	localparam int unsigned MID_DACK0_BIT  = 6;
	localparam int unsigned MID_LMRD_BIT   = 7;

	// field positions inside strap_capture_high
	localparam int unsigned HIGH_LMWR_BIT  = 0;
	localparam int unsigned HIGH_DACK2_BIT = 1;

	// base of each register inside the flat strap vector
	localparam int unsigned VEC_LOW_BASE  = 0;
	localparam int unsigned VEC_MID_BASE  = 8;
	localparam int unsigned VEC_HIGH_BASE = 16;

	// read data after reset and for unmapped indices; straps hold the sampled level
	localparam logic [7:0] RDATA_RST    = 8'h00;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00;

endpackage

// ===== rtl/strap_pad_gate.sv
// releases strap pads during reset so board pulls set their level
`timescale 1ns/1ps
module strap_pad_gate
	import strap_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	// reset
	input  wire logic             in_reset,
	// functional side
	input  wire logic [WIDTH-1:0] func_out,
	input  wire logic [WIDTH-1:0] func_oe,
	// pad side
	output logic      [WIDTH-1:0] pad_out,
	output logic      [WIDTH-1:0] pad_oe
);

	// pads float while reset is held, normal function afterwards
	always_comb begin
		pad_out = func_out;
		pad_oe  = in_reset ? '0 : func_oe;
	end

endmodule

// ===== rtl/strap_capture.sv
// power-on strap capture with three read-only strap registers
`timescale 1ns/1ps
module strap_capture
	import strap_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// ethernet transmit data pads
	input  wire logic [3:0] eth_transmit_data_pin_in,
	output logic      [3:0] eth_transmit_data_pin_out,
	output logic      [3:0] eth_transmit_data_pin_oe,
	// ethernet transmit enable pad
	input  wire logic       eth_transmit_enable_pin_in,
	output logic            eth_transmit_enable_pin_out,
	output logic            eth_transmit_enable_pin_oe,
	// gpio write strobe pad
	input  wire logic       general_io_write_strobe_pin_in,
	output logic            general_io_write_strobe_pin_out,
	output logic            general_io_write_strobe_pin_oe,
	// gpio read strobe pad
	input  wire logic       general_io_read_strobe_pin_in,
	output logic            general_io_read_strobe_pin_out,
	output logic            general_io_read_strobe_pin_oe,
	// dma acknowledge encode pads
	input  wire logic [2:0] dma_ack_encode_line_in,
	output logic      [2:0] dma_ack_encode_line_out,
	output logic      [2:0] dma_ack_encode_line_oe,
	// local bus address pads
	input  wire logic       local_bus_addr_bit22_in,
	output logic            local_bus_addr_bit22_out,
	output logic            local_bus_addr_bit22_oe,
	input  wire logic       local_bus_addr_bit23_in,
	output logic            local_bus_addr_bit23_out,
	output logic            local_bus_addr_bit23_oe,
	input  wire logic       local_bus_addr_bit24_in,
	output logic            local_bus_addr_bit24_out,
	output logic            local_bus_addr_bit24_oe,
	// ethernet management clock pad
	input  wire logic       eth_mgmt_clock_pin_in,
	output logic            eth_mgmt_clock_pin_out,
	output logic            eth_mgmt_clock_pin_oe,
	// serial transmit pad
	input  wire logic       uart_transmit_pin_in,
	output logic            uart_transmit_pin_out,
	output logic            uart_transmit_pin_oe,
	// dma terminal count pad
	input  wire logic       dma_terminal_count_pin_in,
	output logic            dma_terminal_count_pin_out,
	output logic            dma_terminal_count_pin_oe,
	// low-memory strobe pads
	input  wire logic       low_mem_read_strobe_pin_in,
	output logic            low_mem_read_strobe_pin_out,
	output logic            low_mem_read_strobe_pin_oe,
	input  wire logic       low_mem_write_strobe_pin_in,
	output logic            low_mem_write_strobe_pin_out,
	output logic            low_mem_write_strobe_pin_oe,
	// normal-function drive, indexed like the flat strap vector
	input  wire logic [17:0] func_out,
	input  wire logic [17:0] func_oe,
	// index/data register port
	input  wire logic [7:0] reg_index,
	input  wire logic       reg_rd_en,
	input  wire logic       reg_wr_en,
	output logic      [7:0] reg_rdata,
	output logic            reg_rdata_valid,
	output logic            reg_wr_rejected,
	// captured strap values for the rest of the chip
	output logic      [7:0] strap_low,
	output logic      [7:0] strap_mid,
	output logic      [7:0] strap_high
);

	// one packed record holds every flip-flop of the block:
	// the three captured straps, the registered read answer and the write-refused flag
	typedef struct packed {
		logic [7:0] low;
		logic [7:0] mid;
		logic [7:0] high;
		logic [7:0] rdata;
		logic       rvalid;
		logic       wr_rej;
	} state_t;

	// st_q holds the flip-flops, st_d their next value
	state_t st_q;
	state_t st_d;

	// flat strap vector: low bits 0..7, mid 8..15, high 16..17
	logic [STRAP_PINS-1:0] pin_vec;
	logic [STRAP_PINS-1:0] pad_out_vec;
	logic [STRAP_PINS-1:0] pad_oe_vec;
	logic                  idx_hit;

	// gather pad levels into register bit order
	// pads are read all the time; the next-state logic decides when they count
	always_comb begin
		pin_vec = '0;
		pin_vec[VEC_LOW_BASE+LOW_ETH_TXD_LSB +: 4]  = eth_transmit_data_pin_in;
		pin_vec[VEC_LOW_BASE+LOW_ETH_TXEN_BIT]      = eth_transmit_enable_pin_in;
		pin_vec[VEC_LOW_BASE+LOW_GIO_WR_BIT]        = general_io_write_strobe_pin_in;
		pin_vec[VEC_LOW_BASE+LOW_GIO_RD_BIT]        = general_io_read_strobe_pin_in;
		pin_vec[VEC_LOW_BASE+LOW_DACK1_BIT]         = dma_ack_encode_line_in[1];
		pin_vec[VEC_MID_BASE+MID_LBA22_BIT]         = local_bus_addr_bit22_in;
		pin_vec[VEC_MID_BASE+MID_LBA23_BIT]         = local_bus_addr_bit23_in;
		pin_vec[VEC_MID_BASE+MID_LBA24_BIT]         = local_bus_addr_bit24_in;
		pin_vec[VEC_MID_BASE+MID_MDC_BIT]           = eth_mgmt_clock_pin_in;
		pin_vec[VEC_MID_BASE+MID_UART_BIT]          = uart_transmit_pin_in;
		pin_vec[VEC_MID_BASE+MID_DMATC_BIT]         = dma_terminal_count_pin_in;
		pin_vec[VEC_MID_BASE+MID_DACK0_BIT]         = dma_ack_encode_line_in[0];
		pin_vec[VEC_MID_BASE+MID_LMRD_BIT]          = low_mem_read_strobe_pin_in;
		pin_vec[VEC_HIGH_BASE+HIGH_LMWR_BIT]        = low_mem_write_strobe_pin_in;
		pin_vec[VEC_HIGH_BASE+HIGH_DACK2_BIT]       = dma_ack_encode_line_in[2];
	end

	// pad release during reset
	// a pad driven in reset would mask the board pull it is meant to sense
	strap_pad_gate #(
		.WIDTH    (STRAP_PINS)
	) u_pad_gate (
		.in_reset (sys_rst),
		.func_out (func_out),
		.func_oe  (func_oe),
		.pad_out  (pad_out_vec),
		.pad_oe   (pad_oe_vec)
	);

	// scatter gated drive back onto the named pads
	// dma ack lines sit in all three registers, so each bit is routed alone
	always_comb begin
		eth_transmit_data_pin_out       = pad_out_vec[VEC_LOW_BASE+LOW_ETH_TXD_LSB +: 4];
		eth_transmit_data_pin_oe        = pad_oe_vec[VEC_LOW_BASE+LOW_ETH_TXD_LSB +: 4];
		eth_transmit_enable_pin_out     = pad_out_vec[VEC_LOW_BASE+LOW_ETH_TXEN_BIT];
		eth_transmit_enable_pin_oe      = pad_oe_vec[VEC_LOW_BASE+LOW_ETH_TXEN_BIT];
		general_io_write_strobe_pin_out = pad_out_vec[VEC_LOW_BASE+LOW_GIO_WR_BIT];
		general_io_write_strobe_pin_oe  = pad_oe_vec[VEC_LOW_BASE+LOW_GIO_WR_BIT];
		general_io_read_strobe_pin_out  = pad_out_vec[VEC_LOW_BASE+LOW_GIO_RD_BIT];
		general_io_read_strobe_pin_oe   = pad_oe_vec[VEC_LOW_BASE+LOW_GIO_RD_BIT];
		dma_ack_encode_line_out[0]      = pad_out_vec[VEC_MID_BASE+MID_DACK0_BIT];
		dma_ack_encode_line_oe[0]       = pad_oe_vec[VEC_MID_BASE+MID_DACK0_BIT];
		dma_ack_encode_line_out[1]      = pad_out_vec[VEC_LOW_BASE+LOW_DACK1_BIT];
		dma_ack_encode_line_oe[1]       = pad_oe_vec[VEC_LOW_BASE+LOW_DACK1_BIT];
		dma_ack_encode_line_out[2]      = pad_out_vec[VEC_HIGH_BASE+HIGH_DACK2_BIT];
		dma_ack_encode_line_oe[2]       = pad_oe_vec[VEC_HIGH_BASE+HIGH_DACK2_BIT];
		local_bus_addr_bit22_out        = pad_out_vec[VEC_MID_BASE+MID_LBA22_BIT];
		local_bus_addr_bit22_oe         = pad_oe_vec[VEC_MID_BASE+MID_LBA22_BIT];
		local_bus_addr_bit23_out        = pad_out_vec[VEC_MID_BASE+MID_LBA23_BIT];
		local_bus_addr_bit23_oe         = pad_oe_vec[VEC_MID_BASE+MID_LBA23_BIT];
		local_bus_addr_bit24_out        = pad_out_vec[VEC_MID_BASE+MID_LBA24_BIT];
		local_bus_addr_bit24_oe         = pad_oe_vec[VEC_MID_BASE+MID_LBA24_BIT];
		eth_mgmt_clock_pin_out          = pad_out_vec[VEC_MID_BASE+MID_MDC_BIT];
		eth_mgmt_clock_pin_oe           = pad_oe_vec[VEC_MID_BASE+MID_MDC_BIT];
		uart_transmit_pin_out           = pad_out_vec[VEC_MID_BASE+MID_UART_BIT];
		uart_transmit_pin_oe            = pad_oe_vec[VEC_MID_BASE+MID_UART_BIT];
		dma_terminal_count_pin_out      = pad_out_vec[VEC_MID_BASE+MID_DMATC_BIT];
		dma_terminal_count_pin_oe       = pad_oe_vec[VEC_MID_BASE+MID_DMATC_BIT];
		low_mem_read_strobe_pin_out     = pad_out_vec[VEC_MID_BASE+MID_LMRD_BIT];
		low_mem_read_strobe_pin_oe      = pad_oe_vec[VEC_MID_BASE+MID_LMRD_BIT];
		low_mem_write_strobe_pin_out    = pad_out_vec[VEC_HIGH_BASE+HIGH_LMWR_BIT];
		low_mem_write_strobe_pin_oe     = pad_oe_vec[VEC_HIGH_BASE+HIGH_LMWR_BIT];
	end

	// index matches one of the strap registers
	// only these indices count as a refused write
	always_comb begin
		idx_hit = (reg_index == IDX_STRAP_LOW) || (reg_index == IDX_STRAP_MID) ||
			(reg_index == IDX_STRAP_HIGH);
	end

	// next state: capture in reset, hold and serve reads afterwards
	always_comb begin
		st_d        = st_q;
		// answer flags are one-cycle pulses by default
		st_d.rvalid = 1'b0;
		st_d.wr_rej = 1'b0;
		if (sys_rst) begin
			// sampled every reset cycle, so the last edge of reset wins
			st_d.low    = pin_vec[VEC_LOW_BASE +: REG_W];
			st_d.mid    = pin_vec[VEC_MID_BASE +: REG_W];
			st_d.high   = {6'h00, pin_vec[VEC_HIGH_BASE +: 2]};
			st_d.rdata  = RDATA_RST;
		end else begin
			// straps kept as is; writes only flag the attempt
			if (reg_wr_en && idx_hit) begin
				st_d.wr_rej = 1'b1;
			end
			// reads always answer; unmapped indices give a fixed byte
			if (reg_rd_en) begin
				st_d.rvalid = 1'b1;
				unique case (reg_index)
					IDX_STRAP_LOW:  st_d.rdata = st_q.low;
					IDX_STRAP_MID:  st_d.rdata = st_q.mid;
					IDX_STRAP_HIGH: st_d.rdata = st_q.high;
					default:        st_d.rdata = UNMAPPED_VAL;
				endcase
			end
		end
	end

	// single state register; no write path reaches the strap fields
	// no reset branch: the capture itself runs while sys_rst is high
	always_ff @(posedge core_clk) begin
		st_q <= st_d;
	end

	// registered outputs
	// straps reach the rest of the chip straight from flip-flops
	always_comb begin
		reg_rdata       = st_q.rdata;
		reg_rdata_valid = st_q.rvalid;
		reg_wr_rejected = st_q.wr_rej;
		strap_low       = st_q.low;
		strap_mid       = st_q.mid;
		strap_high      = st_q.high;
	end

endmodule

// ===== test/strap_capture_monitor.sv
// assertion checker on the strap capture ports
`timescale 1ns/1ps
module strap_capture_monitor
	import strap_pkg::*;
(
	// clock, reset and watched pads
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic [3:0] eth_transmit_data_pin_in,
	input wire logic [3:0] eth_transmit_data_pin_oe,
	input wire logic [2:0] dma_ack_encode_line_in,
	// register port and captured values
	input wire logic [7:0] reg_index,
	input wire logic       reg_rd_en,
	input wire logic       reg_wr_en,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rdata_valid,
	input wire logic       reg_wr_rejected,
	input wire logic [7:0] strap_low,
	input wire logic [7:0] strap_mid,
	input wire logic [7:0] strap_high
);
	// single domain, register checks idle in reset
	default clocking dcb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// pads released and levels taken while reset is held
	AST_OE_RST: assert property (disable iff (1'b0) sys_rst |->
		eth_transmit_data_pin_oe == 4'h0) else $error("strap pad driven during reset");
	AST_CAP_TXD: assert property (disable iff (1'b0) sys_rst |=>
		strap_low[3:0] == $past(eth_transmit_data_pin_in)) else $error("txd strap lost");
	AST_CAP_DACK: assert property (disable iff (1'b0) sys_rst |=>
		{strap_high[1], strap_low[7], strap_mid[6]} == $past(dma_ack_encode_line_in))
		else $error("dma ack strap lost");
	// frozen values and read-back after release
	AST_HOLD: assert property (!sys_rst |=> $stable({strap_high, strap_mid, strap_low}))
		else $error("strap changed outside reset");
	AST_RD_LOW: assert property (reg_rd_en && reg_index == IDX_STRAP_LOW |=>
		reg_rdata_valid && reg_rdata == strap_low) else $error("low strap read wrong");
	AST_RD_MID: assert property (reg_rd_en && reg_index == IDX_STRAP_MID |=>
		reg_rdata_valid && reg_rdata == strap_mid) else $error("mid strap read wrong");
	AST_RD_HIGH: assert property (reg_rd_en && reg_index == IDX_STRAP_HIGH |=>
		reg_rdata == {6'h00, strap_high[1:0]}) else $error("high strap read wrong");
	AST_WR_REJ: assert property (reg_wr_en && reg_index == IDX_STRAP_MID |=>
		reg_wr_rejected && $stable(strap_mid)) else $error("strap write not refused");
endmodule

// ===== test/strap_board.sv
// board pull resistors on the strap pads
`timescale 1ns/1ps
module strap_board (
	// pull level per pad and chip drive
	input  wire logic [17:0] pull,
	input  wire logic [17:0] out,
	input  wire logic [17:0] oe,
	// resulting pad level
	output logic      [17:0] pad
);
	// a released pad settles to its pull level
	assign pad = (oe & out) | (~oe & pull);
endmodule

// ===== test/power_on_strap_capture_tb.sv
// self-checking bench for the power-on strap capture block
`timescale 1ns/1ps
module power_on_strap_capture_tb
	import strap_pkg::*;
;
	// stimulus and observed nets
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [17:0] pull = 18'h00000, fo = 18'h00000, fe = 18'h00000;
	logic [7:0]  reg_index = 8'h00;
	logic        reg_rd_en = 1'b0, reg_wr_en = 1'b0;
	wire  [17:0] p, o, e;
	wire  [7:0]  reg_rdata, strap_low, strap_mid, strap_high;
	wire         reg_rdata_valid, reg_wr_rejected;
	int          fail_count = 0, n_checks = 0;
	// 125 MHz clock
	always #4 core_clk = ~core_clk;
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) fail_count++;
		if (seen !== exp) $display("unexpected %s expected %h seen %h", what, exp, seen);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// register image expected for given pad levels
	function automatic logic [7:0] exp_reg(input logic [17:0] s, input logic [7:0] i);
		if (i == IDX_STRAP_LOW) return s[7:0];
		if (i == IDX_STRAP_MID) return s[15:8];
		return (i == IDX_STRAP_HIGH) ? {6'h00, s[17:16]} : 8'h00;
	endfunction
	// reset for three cycles, pads only reach s on the last one; returns on a rising edge
	task automatic do_reset(input logic [17:0] s);
		sys_rst <= 1'b1;
		pull <= ~s;
		fe <= 18'h3FFFF;
		repeat (2) @(posedge core_clk);
		check("oe in reset", e, 24'h000000);
		pull <= s;
		@(posedge core_clk);
		sys_rst <= 1'b0;
		pull <= ~s;
		@(negedge core_clk);
		check("captured", {strap_high, strap_mid, strap_low}, {6'h00, s});
		@(posedge core_clk);
	endtask
	// read and write one index in the same cycle, answer looked at mid-cycle
	task automatic access(input logic [7:0] i, input logic [17:0] s);
		logic hit;
		hit = (i >= IDX_STRAP_LOW) && (i <= IDX_STRAP_HIGH);
		reg_index <= i;
		reg_rd_en <= 1'b1;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		reg_wr_en <= 1'b0;
		@(negedge core_clk);
		check("read", {reg_rdata_valid, reg_rdata}, {1'b1, exp_reg(s, i)});
		check("write refused", reg_wr_rejected, hit);
		check("pad oe", e, fe);
		check("pad out", o, fo);
		@(posedge core_clk);
	endtask
	// design and board
	strap_capture dut (
		.core_clk, .sys_rst, .func_out(fo), .func_oe(fe), .reg_index, .reg_rd_en, .reg_wr_en,
		.reg_rdata, .reg_rdata_valid, .reg_wr_rejected, .strap_low, .strap_mid, .strap_high,
		.eth_transmit_data_pin_in(p[3:0]), .eth_transmit_data_pin_out(o[3:0]),
		.eth_transmit_data_pin_oe(e[3:0]), .eth_transmit_enable_pin_in(p[4]),
		.eth_transmit_enable_pin_out(o[4]), .eth_transmit_enable_pin_oe(e[4]),
		.general_io_write_strobe_pin_in(p[5]), .general_io_write_strobe_pin_out(o[5]),
		.general_io_write_strobe_pin_oe(e[5]), .general_io_read_strobe_pin_in(p[6]),
		.general_io_read_strobe_pin_out(o[6]), .general_io_read_strobe_pin_oe(e[6]),
		.dma_ack_encode_line_in({p[17], p[7], p[14]}),
		.dma_ack_encode_line_out({o[17], o[7], o[14]}),
		.dma_ack_encode_line_oe({e[17], e[7], e[14]}), .local_bus_addr_bit22_in(p[8]),
		.local_bus_addr_bit22_out(o[8]), .local_bus_addr_bit22_oe(e[8]),
		.local_bus_addr_bit23_in(p[9]), .local_bus_addr_bit23_out(o[9]),
		.local_bus_addr_bit23_oe(e[9]), .local_bus_addr_bit24_in(p[10]),
		.local_bus_addr_bit24_out(o[10]), .local_bus_addr_bit24_oe(e[10]),
		.eth_mgmt_clock_pin_in(p[11]), .eth_mgmt_clock_pin_out(o[11]), .eth_mgmt_clock_pin_oe(e[11]),
		.uart_transmit_pin_in(p[12]), .uart_transmit_pin_out(o[12]), .uart_transmit_pin_oe(e[12]),
		.dma_terminal_count_pin_in(p[13]), .dma_terminal_count_pin_out(o[13]),
		.dma_terminal_count_pin_oe(e[13]), .low_mem_read_strobe_pin_in(p[15]),
		.low_mem_read_strobe_pin_out(o[15]), .low_mem_read_strobe_pin_oe(e[15]),
		.low_mem_write_strobe_pin_in(p[16]), .low_mem_write_strobe_pin_out(o[16]),
		.low_mem_write_strobe_pin_oe(e[16])
	);
	strap_board board (.pull, .out(o), .oe(e), .pad(p));
	// corner and random strap patterns, each through a full reset
	initial begin
		logic [17:0] s;
		void'($urandom(7));
		for (int k = 0; k < 6; k++) begin
			s = (k == 0) ? 18'h00000 : (k == 1) ? 18'h3FFFF : 18'($urandom);
			do_reset(s);
			for (int j = 0; j < 10; j++) begin
				fo <= 18'($urandom);
				fe <= 18'($urandom);
				access(8'((j < 4) ? IDX_STRAP_LOW + j : 8'h48 + $urandom_range(5)), s);
			end
			check("held", {strap_high, strap_mid, strap_low}, {6'h00, s});
		end
		wrap_up();
	end
endmodule
bind strap_capture strap_capture_monitor mon (
	.core_clk, .sys_rst, .eth_transmit_data_pin_in, .eth_transmit_data_pin_oe,
	.dma_ack_encode_line_in, .reg_index, .reg_rd_en, .reg_wr_en, .reg_rdata,
	.reg_rdata_valid, .reg_wr_rejected, .strap_low, .strap_mid, .strap_high
);
